// ==== include/lbam_pkg.sv ====
// Package for the leaky-bucket activity monitor: register map, fields, resets, timing.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
package lbam_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_DRAIN_RATE_CFG2 = 8'h5B;
    localparam logic [7:0] ADDR_SET_LIMIT_CFG3 = 8'h5C;
    localparam logic [7:0] ADDR_CLEAR_LIMIT_CFG3 = 8'h5D;
    localparam logic [7:0] ADDR_BUCKET_MAX_CFG3 = 8'h5E;
    localparam logic [7:0] ADDR_STATUS = 8'h60;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h64;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h68;
    localparam logic [7:0] ADDR_CONTROL = 8'h6C;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_DRAIN_RATE = 8'h01;
    localparam logic [7:0] RST_SET_LIMIT = 8'h06;
    localparam logic [7:0] RST_CLEAR_LIMIT = 8'h04;
    localparam logic [7:0] RST_BUCKET_MAX = 8'h08;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int DRAIN_LSB = 0;
    localparam int DRAIN_W = 2;
    localparam int IRQ_RAISE_BIT = 0;
    localparam int IRQ_CLEAR_BIT = 1;
    localparam int STAT_ALARM_BIT = 8;
    localparam int CTRL_SRC_BIT = 0;
    localparam logic [1:0] IRQ_W_ONES = 2'h3;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam longint CLK_HZ = 125000000;
    localparam longint EVAL_MS = 128;
    localparam longint EVAL_CYCLES = (CLK_HZ * EVAL_MS) / 1000;
endpackage : lbam_pkg

// ==== include/lbam_evt_if.sv ====
// Carrier between the monitor top and its bucket core.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface lbam_evt_if;
    logic tick;
    logic fault;
    logic [1:0] drainRate;
    logic [7:0] setLimit;
    logic [7:0] clearLimit;
    logic [7:0] bucketMax;
    logic [7:0] level;
    logic alarm;
    modport ctrl (output tick, output fault, output drainRate, output setLimit, output clearLimit,
        output bucketMax, input level, input alarm);
    modport core (input tick, input fault, input drainRate, input setLimit, input clearLimit,
        input bucketMax, output level, output alarm);
endinterface : lbam_evt_if

// ==== core/lbam_bucket.sv ====
// Leaky-bucket accumulator with alarm hysteresis.
// Assumes one tick per evaluation cycle and fault held valid with it.
`timescale 1ns/1ps
module lbam_bucket (
    input wire logic clk,
    input wire logic rst_n,
    lbam_evt_if.core evt
);
    logic [7:0] level_r;
    logic [7:0] level_nxt;
    logic alarm_r;
    logic alarm_nxt;
    logic [2:0] quiet_r;
    logic [2:0] quiet_nxt;
    logic [2:0] periodMask;
    logic drainDue;
    logic canFill;
    logic canDrain;

    // ----------------------------------------
    // Drain period select
    // ----------------------------------------
    assign periodMask = (evt.drainRate == 2'h0) ? 3'h0 :
                        (evt.drainRate == 2'h1) ? 3'h1 :
                        (evt.drainRate == 2'h2) ? 3'h3 : 3'h7;
    assign drainDue = ((quiet_r & periodMask) == periodMask);
    assign canFill = (level_r < evt.bucketMax);
    assign canDrain = (level_r != 8'h00);

    assign quiet_nxt = !evt.tick ? quiet_r :
                       (evt.fault || drainDue) ? 3'h0 : quiet_r + 3'h1;
    assign level_nxt = !evt.tick ? level_r :
                       evt.fault ? (canFill ? level_r + 8'h01 : level_r) :
                       (drainDue && canDrain) ? level_r - 8'h01 : level_r;
    // Hysteresis: set wins if both limits coincide; judged only at a window end
    assign alarm_nxt = !evt.tick ? alarm_r :
                       (level_nxt >= evt.setLimit) ? 1'b1 :
                       (level_nxt <= evt.clearLimit) ? 1'b0 : alarm_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level_r <= 8'h00;
            quiet_r <= 3'h0;
            alarm_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
            quiet_r <= quiet_nxt;
            alarm_r <= alarm_nxt;
        end
    end

    assign evt.level = level_r;
    assign evt.alarm = alarm_r;
endmodule : lbam_bucket

// ==== core/lbam_monitor.sv ====
// Leaky-bucket activity monitor top: Avalon-MM registers, evaluation timer, interrupt.
// Assumes fault inputs are asynchronous pins; single 125 MHz clock, synchronous reset.
//
// What this block does
// - Judge the input once per fixed 128 ms evaluation cycle.
// - Each faulty or erratic cycle adds one to the bucket, or nothing once the count is at the bucket maximum.
// - Each quiet decay period of 1, 2, 4 or 8 cycles subtracts one.
// - Decay code 00/01/10/11 gives 128/256/512/1024 ms per decrement.
// - Decay setting sits in bits 1:0; bits 7:2 unused.
// - Alarm rises when the count reaches the upper threshold.
// - Upper threshold is an 8-bit read/write register at 5C.
// - Programmable lower threshold; alarm clears when count falls to it.
// - Programmable bucket maximum; a fault never raises the count past it.
`timescale 1ns/1ps
module lbam_monitor #(
    parameter longint EVAL_CYCLES = lbam_pkg::EVAL_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic failIn,
    input wire logic erraticIn,
    output logic alarmOut,
    output logic irq
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [2:0] failSync_r;
    logic [2:0] errSync_r;
    logic failStable_r;
    logic errStable_r;
    logic sawFault_r;
    logic sawFault_nxt;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            failSync_r <= 3'h0;
            errSync_r <= 3'h0;
        end else begin
            failSync_r <= {failSync_r[1:0], failIn};
            errSync_r <= {errSync_r[1:0], erraticIn};
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            failStable_r <= 1'b0;
            errStable_r <= 1'b0;
        end else begin
            if (failSync_r[1] == failSync_r[2]) begin
                failStable_r <= failSync_r[2];
            end
            if (errSync_r[1] == errSync_r[2]) begin
                errStable_r <= errSync_r[2];
            end
        end
    end

    // ----------------------------------------
    // Evaluation timer
    // ----------------------------------------
    logic [31:0] evalCnt_r;
    logic [31:0] evalCnt_nxt;
    logic tick_r;
    logic evalEnd;

    assign evalEnd = (evalCnt_r == 32'(EVAL_CYCLES - 1));
    assign evalCnt_nxt = evalEnd ? 32'h0 : evalCnt_r + 32'h1;
    // Any fault seen during the window is latched until its end
    assign sawFault_nxt = evalEnd ? 1'b0 : (sawFault_r | failStable_r | errStable_r);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evalCnt_r <= 32'h0;
            tick_r <= 1'b0;
            sawFault_r <= 1'b0;
        end else begin
            evalCnt_r <= evalCnt_nxt;
            tick_r <= evalEnd;
            sawFault_r <= sawFault_nxt;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] drainRate_r;
    logic [7:0] setLimit_r;
    logic [7:0] clearLimit_r;
    logic [7:0] bucketMax_r;
    logic [1:0] irqStatus_r;
    logic [1:0] irqStatus_nxt;
    logic [1:0] irqMask_r;
    logic judged_r;
    logic waitPend_r;
    logic [31:0] rdData_r;
    logic [31:0] rdData_nxt;
    logic alarmOut_r;
    logic irq_r;
    logic alarmPrev_r;
    logic waitReq_r;

    lbam_evt_if evt ();

    // Fault of the just-closed window goes with the tick
    assign evt.tick = tick_r;
    assign evt.fault = judged_r;
    assign evt.drainRate = drainRate_r[lbam_pkg::DRAIN_LSB +: lbam_pkg::DRAIN_W];
    assign evt.setLimit = setLimit_r;
    assign evt.clearLimit = clearLimit_r;
    assign evt.bucketMax = bucketMax_r;

    lbam_bucket u_bucket (
        .clk(clk),
        .rst_n(rst_n),
        .evt(evt)
    );

    // One wait state: the access completes on the second edge
    logic busAccess;
    logic accDone;
    logic wrEn;
    logic wrLow;
    logic selDrain;
    logic selSet;
    logic selClear;
    logic selMax;
    logic selIrqS;
    logic selIrqM;

    assign busAccess = avs_read | avs_write;
    assign accDone = busAccess & waitPend_r;
    assign wrEn = avs_write & waitPend_r;
    assign wrLow = wrEn & avs_byteenable[0];
    assign selDrain = (avs_address == lbam_pkg::ADDR_DRAIN_RATE_CFG2);
    assign selSet = (avs_address == lbam_pkg::ADDR_SET_LIMIT_CFG3);
    assign selClear = (avs_address == lbam_pkg::ADDR_CLEAR_LIMIT_CFG3);
    assign selMax = (avs_address == lbam_pkg::ADDR_BUCKET_MAX_CFG3);
    assign selIrqS = (avs_address == lbam_pkg::ADDR_IRQ_STATUS);
    assign selIrqM = (avs_address == lbam_pkg::ADDR_IRQ_MASK);

    // Events: alarm raised and alarm cleared; set wins over a write-one clear
    logic raiseEvt;
    logic clearEvt;
    logic [1:0] irqClr;
    assign raiseEvt = evt.alarm & ~alarmPrev_r;
    assign clearEvt = ~evt.alarm & alarmPrev_r;
    assign irqClr = (wrLow & selIrqS) ? avs_writedata[1:0] : 2'h0;
    assign irqStatus_nxt = (irqStatus_r & ~irqClr) | {clearEvt, raiseEvt};

    // Unmapped addresses read as zero; writes to them are dropped
    assign rdData_nxt =
        selDrain ? {24'h0, 6'h0, drainRate_r[1:0]} :
        selSet ? {24'h0, setLimit_r} :
        selClear ? {24'h0, clearLimit_r} :
        selMax ? {24'h0, bucketMax_r} :
        (avs_address == lbam_pkg::ADDR_STATUS) ? {23'h0, evt.alarm, evt.level} :
        selIrqS ? {30'h0, irqStatus_r} :
        selIrqM ? {30'h0, irqMask_r} :
        32'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitPend_r <= 1'b0;
            waitReq_r <= 1'b1;
            rdData_r <= 32'h0;
        end else begin
            waitPend_r <= busAccess & ~waitPend_r;
            // Kept as its own flop so the port comes straight from a register
            waitReq_r <= ~(busAccess & ~waitPend_r);
            rdData_r <= (avs_read & ~waitPend_r) ? rdData_nxt : rdData_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drainRate_r <= lbam_pkg::RST_DRAIN_RATE;
            setLimit_r <= lbam_pkg::RST_SET_LIMIT;
            clearLimit_r <= lbam_pkg::RST_CLEAR_LIMIT;
            bucketMax_r <= lbam_pkg::RST_BUCKET_MAX;
            irqMask_r <= lbam_pkg::RST_IRQ_MASK;
        end else if (wrLow) begin
            if (selDrain) begin
                drainRate_r <= {6'h0, avs_writedata[1:0]};
            end
            if (selSet) begin
                setLimit_r <= avs_writedata[7:0];
            end
            if (selClear) begin
                clearLimit_r <= avs_writedata[7:0];
            end
            if (selMax) begin
                bucketMax_r <= avs_writedata[7:0];
            end
            if (selIrqM) begin
                irqMask_r <= avs_writedata[1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqStatus_r <= 2'h0;
            alarmPrev_r <= 1'b0;
            alarmOut_r <= 1'b0;
            irq_r <= 1'b0;
            judged_r <= 1'b0;
        end else begin
            irqStatus_r <= irqStatus_nxt;
            alarmPrev_r <= evt.alarm;
            alarmOut_r <= evt.alarm;
            irq_r <= |(irqStatus_nxt & irqMask_r);
            // Latched flag of the closing window, not its cleared next value
            judged_r <= evalEnd ? sawFault_r | failStable_r | errStable_r : judged_r;
        end
    end

    assign avs_readdata = rdData_r;
    assign avs_waitrequest = waitReq_r;
    assign alarmOut = alarmOut_r;
    assign irq = irq_r;
endmodule : lbam_monitor

// ==== tb/lbam_fault_src.sv ====
// Model of the reference fault detectors that feed the monitor's fault pins.
// Assumes one clock; the bench picks the fault kind per stretch of windows.
`timescale 1ns/1ps
module lbam_fault_src (
    input wire logic clk,
    input wire logic [1:0] faultKind,
    output logic failIn,
    output logic erraticIn
);
    logic [2:0] phase_r = 3'h0;
    initial failIn = 1'b0;
    initial erraticIn = 1'b0;
    // Erratic bursts stay 5 cycles high so the pin filter still sees them
    always @(posedge clk) begin
        phase_r <= phase_r + 3'h1;
        failIn <= (faultKind == 2'h1);
        erraticIn <= (faultKind == 2'h2) && (phase_r < 3'h5);
    end
endmodule : lbam_fault_src

// ==== tb/lbam_monitor_sva.sv ====
// Checker of the monitor's bus handshake, read data and alarm timing.
// Assumes it is bound to lbam_monitor and sees only its ports.
`timescale 1ns/1ps
module lbam_monitor_sva #(
    parameter longint EVAL_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic failIn,
    input wire logic erraticIn,
    input wire logic alarmOut,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    longint gapCnt_r;
    wire logic reqTaken = (avs_read || avs_write) && avs_waitrequest;
    wire logic rdTaken = avs_read && avs_waitrequest;
    // Alarm can only move at a window end, so two moves lie a whole window apart
    always_ff @(posedge clk) begin
        if (!rst_n) gapCnt_r <= 0;
        else gapCnt_r <= $changed(alarmOut) ? 0 : gapCnt_r + 1;
    end
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");
    property p_answer; reqTaken |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_idle; !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_rd_hold; !rdTaken |=> $stable(avs_readdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unmapped; rdTaken && avs_address == 8'h6C |=> avs_readdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("reserved read not zero");
    property p_drain_bits; rdTaken && avs_address == 8'h5B |=> avs_readdata[31:2] == 30'h0; endproperty
    a_drain_bits: assert property (p_drain_bits) else $error("unused drain bits set");
    property p_status_alarm; rdTaken && avs_address == 8'h60 |=> avs_readdata[8] == alarmOut; endproperty
    a_status_alarm: assert property (p_status_alarm) else $error("status alarm mismatch");
    property p_alarm_gap; $changed(alarmOut) |-> gapCnt_r >= EVAL_CYCLES - 1; endproperty
    a_alarm_gap: assert property (p_alarm_gap) else $error("alarm moved inside a window");
endmodule : lbam_monitor_sva
bind lbam_monitor lbam_monitor_sva #(.EVAL_CYCLES(EVAL_CYCLES)) u_sva (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .failIn(failIn), .erraticIn(erraticIn), .alarmOut(alarmOut), .irq(irq));

// ==== tb/testbench.sv ====
// Self-checking bench for the monitor: registers, fill, drain rates, alarm and interrupt.
// Assumes a short evaluation window so each window is EVC clock cycles.
`timescale 1ns/1ps
module testbench;
    localparam int EVC = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, failIn, erraticIn, alarmOut, irq;
    logic [1:0] faultKind = 2'h0;
    logic [31:0] rd;
    int n_errors = 0;
    int num_checks = 0;
    int seed = 32'h73f5;
    int cyc = 0;
    logic [7:0] regAddr[6] = '{8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h68, 8'h6C};
    logic [7:0] regRst[6] = '{8'h01, 8'h06, 8'h04, 8'h08, 8'h00, 8'h00};
    always #4 clk = ~clk;
    lbam_monitor #(.EVAL_CYCLES(EVC)) DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .failIn(failIn), .erraticIn(erraticIn), .alarmOut(alarmOut), .irq(irq));
    lbam_fault_src SRC (.clk(clk), .faultKind(faultKind), .failIn(failIn), .erraticIn(erraticIn));
    function automatic int exp_gap(input int code);
        return EVC << code;
    endfunction : exp_gap
    task automatic close_out();
        $display("Checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // Request held until waitrequest is sampled low; the slave decides the latency
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic poll_level(input logic [7:0] want);
        do bus(1'b0, 8'h60, 32'h0); while (rd[7:0] !== want);
    endtask : poll_level
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            close_out();
        end
    end
    initial begin
        int i;
        int t1;
        logic [31:0] w;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) begin
            bus(1'b0, regAddr[i], 32'h0);
            check(rd, {24'h0, regRst[i]});
        end
        for (i = 0; i < 8; i++) begin
            w = $random(seed);
            bus(1'b1, 8'h5C, w);
            bus(1'b0, 8'h5C, 32'h0);
            check(rd, {24'h0, w[7:0]});
            bus(1'b1, 8'h5B, w);
            bus(1'b0, 8'h5B, 32'h0);
            check(rd, {30'h0, w[1:0]});
        end
        avs_byteenable <= 4'h0;
        bus(1'b1, 8'h5C, 32'h0);
        avs_byteenable <= 4'hF;
        bus(1'b1, 8'h10, 32'hFF);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 8'h5C, 32'h0);
        check(rd, {24'h0, w[7:0]});
        bus(1'b1, 8'h5C, 32'h03);
        bus(1'b1, 8'h5D, 32'h01);
        bus(1'b1, 8'h5E, 32'h04);
        bus(1'b1, 8'h68, 32'h03);
        for (i = 0; i < 4; i++) begin
            bus(1'b1, 8'h5B, i);
            faultKind <= 2'(i % 2 + 1);
            poll_level(8'h01);
            t1 = cyc;
            poll_level(8'h02);
            check((cyc - t1 >= EVC - 4) && (cyc - t1 <= EVC + 4), 1'b1);
            check(rd[8], 1'b0);
            poll_level(8'h03);
            bus(1'b0, 8'h60, 32'h0);
            check(rd, 32'h103);
            check(alarmOut, 1'b1);
            repeat (4 * EVC) @(posedge clk);
            faultKind <= 2'h0;
            bus(1'b0, 8'h60, 32'h0);
            check(rd, 32'h104);
            bus(1'b0, 8'h64, 32'h0);
            check(rd[0], 1'b1);
            check(irq, 1'b1);
            bus(1'b1, 8'h64, 32'h03);
            bus(1'b0, 8'h64, 32'h0);
            check({rd[1:0], irq}, 3'h0);
            poll_level(8'h03);
            t1 = cyc;
            poll_level(8'h02);
            check((cyc - t1 >= exp_gap(i) - 4) && (cyc - t1 <= exp_gap(i) + 4), 1'b1);
            poll_level(8'h00);
            repeat (2 * exp_gap(i)) @(posedge clk);
            bus(1'b0, 8'h60, 32'h0);
            check(rd, 32'h0);
            check(alarmOut, 1'b0);
            bus(1'b0, 8'h64, 32'h0);
            check(rd[1:0], 2'h2);
            bus(1'b1, 8'h64, 32'h03);
        end
        close_out();
    end
endmodule : testbench
